// file: rtl/ppc_cfg.svh
`ifndef PPC_CFG_SVH
`define PPC_CFG_SVH

// register byte offsets
`define PPC_OFS_TMO        8'h5C
`define PPC_OFS_SIZE       8'h60
`define PPC_OFS_MISC       8'h64
`define PPC_OFS_STAT       8'h68

// reset values and writable bits
`define PPC_TMO_RST        16'h0085
`define PPC_SIZE_RST       32'h0017_0ECA
`define PPC_SIZE_WMASK     32'h0017_7FFF
`define PPC_MISC_RST       8'hBA

// prefetch size control fields; per command a 4-bit slot: size at +0, adjust at +3
`define PPC_F_SLOT_ADJ     2'h3
`define PPC_F_LOWER        12
`define PPC_F_UPPER        16
`define PPC_F_MLT          20

// misc control bits
`define PPC_M_CFG_FLUSH    0
`define PPC_M_WR_FLUSH     1
`define PPC_M_RD_FLUSH     2
`define PPC_M_TMO_EN       3
`define PPC_M_MASK_PF      4
`define PPC_M_MASK_NP      5
`define PPC_M_EARLY_FLUSH  6
`define PPC_M_PF_EN        7

// timing: timeout tick of 30 ns, core clock period of 50 ns
`define PPC_TICK_NS        22'd30
`define PPC_CLK_NS         22'd50

// cacheline length in 32-bit words
`define PPC_LINE_WORDS     7'h08

// bus responses
`define PPC_RESP_OKAY      2'h0
`define PPC_RESP_SLVERR    2'h2

`endif

// file: rtl/ppc_pkg.sv
`default_nettype none
package ppc_pkg;

   typedef enum logic [1:0] {
      PPC_CMD_READ = 2'b00,
      PPC_CMD_LINE = 2'b01,
      PPC_CMD_MULT = 2'b10
   } ppc_cmd_t;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_FETCH  = 2'b01,
      ST_STREAM = 2'b10
   } ppc_state_t;

   typedef struct packed {
      ppc_state_t       state;
      ppc_cmd_t         cmd;
      logic [2:0][2:0]  cur;
      logic [15:0]      tmo;
      logic [31:0]      szc;
      logic [7:0]       misc;
      logic             awready;
      logic             wready;
      logic             aw_got;
      logic             w_got;
      logic [7:0]       aw_addr;
      logic [31:0]      w_data;
      logic [3:0]       w_strb;
      logic             bvalid;
      logic [1:0]       bresp;
      logic             arready;
      logic             rvalid;
      logic [31:0]      rdata;
      logic [1:0]       rresp;
      logic             req_ready;
      logic             ib_req_valid;
      logic [31:0]      ib_req_addr;
      logic [2:0]       ib_req_lines;
      logic [31:0]      buf_addr;
      logic             buf_valid;
      logic [6:0]       rem;
      logic             drop;
      logic             short;
      logic             flush_pend;
      logic             flush_pulse;
      logic [21:0]      tmr;
   } ppc_st_t;

endpackage
`default_nettype wire

// file: rtl/ppc_fifo.sv
`default_nettype none
module ppc_fifo #(
   parameter int W = 32,
   parameter int D = 4
) (
   // clock and reset
   input  wire logic          core_clk,
   input  wire logic          rst_n,
   // discard all content
   input  wire logic          flush,
   // fill side
   input  wire logic          in_valid,
   output logic               in_ready,
   input  wire logic [W-1:0]  in_data,
   // drain side
   output logic               out_valid,
   input  wire logic          out_ready,
   output logic [W-1:0]       out_data
);
   localparam int AW = (D > 1) ? $clog2(D) : 1;

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0]       rd;
      logic [AW-1:0]       wr;
      logic [AW:0]         cnt;
      logic                rdy;
      logic                vld;
   } ppc_fifo_st_t;

   ppc_fifo_st_t q;
   ppc_fifo_st_t d;
   logic         push;
   logic         pop;
   logic [AW:0]  cnt_n;

   assign push      = in_valid & q.rdy;
   assign pop       = out_ready & q.vld;
   assign in_ready  = q.rdy;
   assign out_valid = q.vld;
   assign out_data  = q.mem[q.rd];

   always_comb begin
      d     = q;
      cnt_n = q.cnt;
      if (flush) begin
         d.rd  = '0;
         d.wr  = '0;
         cnt_n = '0;
      end else begin
         if (push) begin
            d.mem[q.wr] = in_data;
            d.wr        = (q.wr == AW'(D - 1)) ? '0 : q.wr + 1'b1;
         end
         if (pop) begin
            d.rd = (q.rd == AW'(D - 1)) ? '0 : q.rd + 1'b1;
         end
         cnt_n = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
      end
      d.cnt = cnt_n;
      // flags registered so both handshakes leave straight from flops
      d.rdy = (cnt_n != (AW+1)'(D));
      d.vld = (cnt_n != '0);
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         q     <= '0;
         q.rdy <= 1'b1;
      end else begin
         q <= d;
      end
   end
endmodule
`default_nettype wire

// file: rtl/ppc_prefetch_ctrl.sv
`include "ppc_cfg.svh"
`default_nettype none
module ppc_prefetch_ctrl
   import ppc_pkg::*;
(
   // clock and reset
   input  wire logic         core_clk,
   input  wire logic         rst_n,
   // register bus write address and data
   input  wire logic [7:0]   s_axi_awaddr,
   input  wire logic         s_axi_awvalid,
   output logic              s_axi_awready,
   input  wire logic [31:0]  s_axi_wdata,
   input  wire logic [3:0]   s_axi_wstrb,
   input  wire logic         s_axi_wvalid,
   output logic              s_axi_wready,
   // register bus write response
   output logic [1:0]        s_axi_bresp,
   output logic              s_axi_bvalid,
   input  wire logic         s_axi_bready,
   // register bus read
   input  wire logic [7:0]   s_axi_araddr,
   input  wire logic         s_axi_arvalid,
   output logic              s_axi_arready,
   output logic [31:0]       s_axi_rdata,
   output logic [1:0]        s_axi_rresp,
   output logic              s_axi_rvalid,
   input  wire logic         s_axi_rready,
   // upstream read request from secondary bus master
   input  wire logic         up_req_valid,
   output logic              up_req_ready,
   input  wire logic [1:0]   up_req_cmd,
   input  wire logic [31:0]  up_req_addr,
   // upstream read data to secondary bus master
   output logic              up_xfer_open,
   output logic              up_data_valid,
   input  wire logic         up_data_ready,
   output logic [31:0]       up_data,
   input  wire logic         up_done,
   // fetch request to internal upstream bus
   output logic              ib_req_valid,
   input  wire logic         ib_req_ready,
   output logic [31:0]       ib_req_addr,
   output logic [2:0]        ib_req_lines,
   output logic              ib_mask_pf_req,
   output logic              ib_mask_np_req,
   // fetch data from internal upstream bus
   input  wire logic         ib_rdata_valid,
   output logic              ib_rdata_ready,
   input  wire logic [31:0]  ib_rdata,
   // downstream cycle events
   input  wire logic         ds_arrive,
   input  wire logic         ds_is_cfg,
   input  wire logic         ds_is_write,
   input  wire logic         ds_data_phase,
   // buffer flush notice
   output logic              flush_pulse
);

   ppc_st_t      q;
   ppc_st_t      d;

   logic [1:0]   sel;
   logic [2:0]   fld_size;
   logic         fld_adj;
   logic [2:0]   eff_lines;
   logic [6:0]   words;
   logic [2:0]   lower;
   logic [2:0]   upper;
   logic         want_inc;
   logic         want_dec;
   logic [2:0]   adj_size;
   logic         ds_qual;
   logic         flush_ds;
   logic         tmo_hit;
   logic         flush_all;
   logic         miss_flush;
   logic         fifo_flush;
   logic         f_in_ready;
   logic         f_out_valid;
   logic         push;
   logic         pop;
   logic         leftover;
   logic         starve;
   logic [21:0]  limit_ns;
   logic [31:0]  merged;
   logic [31:0]  size_new;
   logic [31:0]  rd_word;
   logic         rd_err;

   function automatic logic [31:0] ppc_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return r;
   endfunction

   // buffer storage between internal bus and secondary master
   ppc_fifo #(
      .W (32),
      .D (4)
   ) u_buf (
      .core_clk  (core_clk),
      .rst_n     (rst_n),
      .flush     (fifo_flush),
      .in_valid  (ib_rdata_valid),
      .in_ready  (f_in_ready),
      .in_data   (ib_rdata),
      .out_valid (f_out_valid),
      .out_ready (up_data_ready && (q.state == ST_STREAM)),
      .out_data  (up_data)
   );

   assign push = ib_rdata_valid & f_in_ready;
   assign pop  = up_data_ready & f_out_valid & (q.state == ST_STREAM);

   // size selection for the command in flight
   assign sel      = (q.cmd == PPC_CMD_LINE) ? 2'h1 : ((q.cmd == PPC_CMD_MULT) ? 2'h2 : 2'h0);
   assign fld_size = q.szc[{sel, 2'h0} +: 3];
   assign fld_adj  = q.szc[{sel, `PPC_F_SLOT_ADJ}];
   // with the enable clear every read fetches one word only
   assign eff_lines = !q.misc[`PPC_M_PF_EN] ? 3'h0 :
                      (fld_adj ? q.cur[sel] : fld_size);
   assign words = (eff_lines == 3'h0) ? 7'h01 : 7'(eff_lines) * `PPC_LINE_WORDS;

   // automatic size adjustment at the end of a transfer
   assign lower    = q.szc[`PPC_F_LOWER +: 3];
   assign upper    = q.szc[`PPC_F_UPPER +: 3];
   assign leftover = f_out_valid | ((q.rem != 7'h00) & ~q.drop);
   assign starve   = ~f_out_valid & (q.rem == 7'h00) & ~q.drop & up_data_ready;
   always_comb begin
      if (q.szc[`PPC_F_MLT]) begin
         want_inc = q.short & ~leftover;
         want_dec = leftover & ~q.short;
      end else begin
         want_inc = ~leftover;
         want_dec = leftover;
      end
      if (want_inc && (q.cur[sel] < upper)) begin
         adj_size = q.cur[sel] + 3'h1;
      end else if (want_dec && (q.cur[sel] > lower)) begin
         adj_size = q.cur[sel] - 3'h1;
      end else begin
         adj_size = q.cur[sel];
      end
   end

   // flush sources
   assign ds_qual  = ds_arrive & (ds_is_cfg   ? q.misc[`PPC_M_CFG_FLUSH] :
                                  ds_is_write ? q.misc[`PPC_M_WR_FLUSH]  :
                                                q.misc[`PPC_M_RD_FLUSH]);
   assign flush_ds = q.misc[`PPC_M_EARLY_FLUSH] ? ds_qual :
                     (ds_data_phase & (q.flush_pend | ds_qual));
   assign limit_ns = 22'(q.tmo) * `PPC_TICK_NS;
   assign tmo_hit  = q.misc[`PPC_M_TMO_EN] & q.misc[`PPC_M_PF_EN] & q.buf_valid &
                     (q.state == ST_IDLE) & (q.tmr >= limit_ns);
   assign flush_all  = flush_ds | tmo_hit;
   assign miss_flush = (q.state == ST_IDLE) & up_req_valid & q.req_ready &
                       ~(q.buf_valid & (up_req_addr == q.buf_addr));
   // words still owed by the internal bus after a flush are taken and dropped
   assign fifo_flush = flush_all | miss_flush | q.drop;

   // register write data and read decode
   assign merged   = q.aw_addr == `PPC_OFS_TMO  ? ppc_merge({16'h0, q.tmo}, q.w_data, q.w_strb) :
                     q.aw_addr == `PPC_OFS_SIZE ? ppc_merge(q.szc, q.w_data, q.w_strb) :
                     ppc_merge({24'h0, q.misc}, q.w_data, q.w_strb);
   assign size_new = merged & `PPC_SIZE_WMASK;
   always_comb begin
      rd_err = 1'b0;
      if (s_axi_araddr == `PPC_OFS_TMO) begin
         rd_word = {16'h0, q.tmo};
      end else if (s_axi_araddr == `PPC_OFS_SIZE) begin
         rd_word = q.szc;
      end else if (s_axi_araddr == `PPC_OFS_MISC) begin
         rd_word = {24'h0, q.misc};
      end else if (s_axi_araddr == `PPC_OFS_STAT) begin
         rd_word = {11'h0, q.flush_pend, q.drop, q.buf_valid, q.state, 5'h0,
                    q.cur[2], 1'b0, q.cur[1], 1'b0, q.cur[0]};
      end else begin
         rd_word = 32'h0;
         rd_err  = 1'b1;
      end
   end

   always_comb begin
      d             = q;
      d.flush_pulse = flush_all;

      // register bus write: address and data in either order, one at a time
      if (s_axi_awvalid && q.awready) begin
         d.aw_got  = 1'b1;
         d.aw_addr = s_axi_awaddr;
         d.awready = 1'b0;
      end
      if (s_axi_wvalid && q.wready) begin
         d.w_got  = 1'b1;
         d.w_data = s_axi_wdata;
         d.w_strb = s_axi_wstrb;
         d.wready = 1'b0;
      end
      if (q.bvalid && s_axi_bready) begin
         d.bvalid  = 1'b0;
         d.awready = 1'b1;
         d.wready  = 1'b1;
      end

      // register bus read
      if (q.rvalid && s_axi_rready) begin
         d.rvalid  = 1'b0;
         d.arready = 1'b1;
      end
      if (s_axi_arvalid && q.arready) begin
         d.arready = 1'b0;
         d.rvalid  = 1'b1;
         d.rdata   = rd_word;
         d.rresp   = rd_err ? `PPC_RESP_SLVERR : `PPC_RESP_OKAY;
      end

      // downstream flush held until the cycle completes a data phase
      if (flush_ds) begin
         d.flush_pend = 1'b0;
      end else if (ds_qual && !q.misc[`PPC_M_EARLY_FLUSH]) begin
         d.flush_pend = 1'b1;
      end

      // stale timer runs only while held data waits for its owner
      if ((q.state == ST_IDLE) && q.buf_valid) begin
         d.tmr = (q.tmr >= limit_ns) ? q.tmr : q.tmr + `PPC_CLK_NS;
      end else begin
         d.tmr = 22'h0;
      end

      if (push && (q.rem != 7'h00)) begin
         d.rem = q.rem - 7'h01;
      end
      if (pop) begin
         d.buf_addr = q.buf_addr + 32'h4;
      end

      case (q.state)
         ST_IDLE: begin
            if (up_req_valid && q.req_ready) begin
               d.req_ready = 1'b0;
               d.cmd       = ppc_cmd_t'(up_req_cmd);
               d.short     = 1'b0;
               if (q.buf_valid && (up_req_addr == q.buf_addr) && !flush_all) begin
                  d.state = ST_STREAM;
               end else begin
                  d.buf_addr  = up_req_addr;
                  d.buf_valid = 1'b0;
                  d.drop      = (d.rem != 7'h00);
                  d.state     = ST_FETCH;
               end
            end
         end
         ST_FETCH: begin
            if (q.ib_req_valid) begin
               if (ib_req_ready) begin
                  d.ib_req_valid = 1'b0;
                  d.buf_valid    = 1'b1;
                  d.state        = ST_STREAM;
               end
            end else if ((q.rem == 7'h00) && !q.drop) begin
               d.ib_req_valid = 1'b1;
               d.ib_req_addr  = q.buf_addr;
               d.ib_req_lines = eff_lines;
               d.rem          = words;
            end
         end
         ST_STREAM: begin
            if (up_done) begin
               if (fld_adj && q.misc[`PPC_M_PF_EN]) begin
                  d.cur[sel] = adj_size;
               end
               d.req_ready = 1'b1;
               d.state     = ST_IDLE;
            end else if (starve && !pop) begin
               // buffer ran dry while the master still wants data
               d.short = 1'b1;
               d.state = ST_FETCH;
            end
         end
         default: begin
            d.state = ST_IDLE;
         end
      endcase

      // flush empties the buffer; owed words are dropped, not served
      if (flush_all) begin
         d.buf_valid = 1'b0;
         d.drop      = (d.rem != 7'h00);
      end else if (q.drop && (d.rem == 7'h00)) begin
         d.drop = 1'b0;
      end

      // register write takes effect last so software always wins
      if (q.aw_got && q.w_got && !q.bvalid) begin
         d.aw_got = 1'b0;
         d.w_got  = 1'b0;
         d.bvalid = 1'b1;
         d.bresp  = `PPC_RESP_OKAY;
         if (q.aw_addr == `PPC_OFS_TMO) begin
            d.tmo = merged[15:0];
         end else if (q.aw_addr == `PPC_OFS_SIZE) begin
            d.szc = size_new;
            for (int i = 0; i < 3; i++) begin
               d.cur[i] = size_new[4*i +: 3];
            end
         end else if (q.aw_addr == `PPC_OFS_MISC) begin
            d.misc = merged[7:0];
         end else if (q.aw_addr != `PPC_OFS_STAT) begin
            d.bresp = `PPC_RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         q           <= '0;
         q.state     <= ST_IDLE;
         q.tmo       <= `PPC_TMO_RST;
         q.szc       <= `PPC_SIZE_RST;
         q.cur[0]    <= 3'h2;
         q.cur[1]    <= 3'h4;
         q.cur[2]    <= 3'h6;
         q.misc      <= `PPC_MISC_RST;
         q.awready   <= 1'b1;
         q.wready    <= 1'b1;
         q.arready   <= 1'b1;
         q.req_ready <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign s_axi_awready  = q.awready;
   assign s_axi_wready   = q.wready;
   assign s_axi_bvalid   = q.bvalid;
   assign s_axi_bresp    = q.bresp;
   assign s_axi_arready  = q.arready;
   assign s_axi_rvalid   = q.rvalid;
   assign s_axi_rdata    = q.rdata;
   assign s_axi_rresp    = q.rresp;
   assign up_req_ready   = q.req_ready;
   assign up_xfer_open   = (q.state == ST_STREAM);
   assign up_data_valid  = f_out_valid;
   assign ib_req_valid   = q.ib_req_valid;
   assign ib_req_addr    = q.ib_req_addr;
   assign ib_req_lines   = q.ib_req_lines;
   assign ib_mask_pf_req = q.misc[`PPC_M_MASK_PF];
   assign ib_mask_np_req = q.misc[`PPC_M_MASK_NP];
   assign ib_rdata_ready = f_in_ready;
   assign flush_pulse    = q.flush_pulse;
endmodule
`default_nettype wire

// file: bench/ppc_prefetch_ctrl_asserts.sv
`default_nettype none
module ppc_prefetch_ctrl_asserts (
   // clock and reset
   input wire logic        core_clk,
   input wire logic        rst_n,
   // register bus
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   // upstream and internal bus
   input wire logic        up_req_ready,
   input wire logic        up_xfer_open,
   input wire logic        up_done,
   input wire logic        ib_req_valid,
   input wire logic        ib_req_ready,
   input wire logic [31:0] ib_req_addr,
   input wire logic [2:0]  ib_req_lines,
   input wire logic        flush_pulse
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped");
   property p_r_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_r_ans: assert property (p_r_ans) else $error("read answer late");
   property p_ar_blk; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_ar_blk: assert property (p_ar_blk) else $error("read address taken while busy");
   property p_ib_hold;
      ib_req_valid && !ib_req_ready |=> ib_req_valid && $stable({ib_req_addr, ib_req_lines});
   endproperty
   a_ib_hold: assert property (p_ib_hold) else $error("fetch request changed");
   property p_idle; up_req_ready |-> !up_xfer_open; endproperty
   a_idle: assert property (p_idle) else $error("request ready while serving");
   property p_done; up_xfer_open && up_done |=> !up_xfer_open && up_req_ready; endproperty
   a_done: assert property (p_done) else $error("transfer not closed");
   property p_flush_one; flush_pulse |=> !flush_pulse; endproperty
   a_flush_one: assert property (p_flush_one) else $error("flush pulse too long");
   c_flush: cover property (flush_pulse);
   c_fetch: cover property (ib_req_valid && ib_req_ready);
   c_done: cover property (up_xfer_open && up_done);
endmodule
`default_nettype wire

// file: bench/ppc_ib_model.sv
`default_nettype none
module ppc_ib_model (
   // clock and reset
   input wire logic         core_clk,
   input wire logic         rst_n,
   // stall every other cycle when high
   input wire logic         ib_slow,
   // fetch request
   input wire logic         ib_req_valid,
   output logic             ib_req_ready,
   input wire logic [31:0]  ib_req_addr,
   input wire logic [2:0]   ib_req_lines,
   // fetch data
   output logic             ib_rdata_valid,
   input wire logic         ib_rdata_ready,
   output logic [31:0]      ib_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] addr_q;
   logic [6:0]  cnt_q;
   logic        tick_q;
   // one fetch at a time: the whole word count is owed before the next
   assign ib_req_ready = (cnt_q == 7'h00);
   // valid words show the inverted address and idle lines the plain one, so a stale word never looks right
   assign ib_rdata = ib_rdata_valid ? ~addr_q : addr_q;
   always_ff @(posedge core_clk) begin
      tick_q <= ~tick_q;
      if (!rst_n) begin
         cnt_q <= 7'h00;
         ib_rdata_valid <= 1'h0;
         tick_q <= 1'h0;
      end else if (ib_req_valid && ib_req_ready) begin
         addr_q <= ib_req_addr;
         cnt_q <= (ib_req_lines == 3'h0) ? 7'h01 : {1'h0, ib_req_lines, 3'h0};
      end else if (ib_rdata_valid && ib_rdata_ready) begin
         addr_q <= addr_q + 32'h4;
         cnt_q <= cnt_q - 7'h01;
         ib_rdata_valid <= (cnt_q != 7'h01) && !ib_slow;
      end else if (cnt_q != 7'h00 && (!ib_slow || tick_q)) begin
         ib_rdata_valid <= 1'h1;
      end
   end
endmodule
`default_nettype wire

// file: bench/ppc_prefetch_ctrl_tb.sv
`default_nettype none
module ppc_prefetch_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        core_clk = 1'h0, rst_n = 1'h0, ib_slow = 1'h0, up_done = 1'h0;
   logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, up_req_valid = 1'h0;
   logic        up_data_ready = 1'h0, ds_arrive = 1'h0, ds_is_cfg = 1'h0;
   logic        ds_is_write = 1'h0, ds_data_phase = 1'h0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, up_req_addr = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic [1:0]  up_req_cmd = 2'h0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        up_req_ready, up_xfer_open, up_data_valid, ib_req_valid, ib_req_ready;
   logic        ib_mask_pf_req, ib_mask_np_req, ib_rdata_valid, ib_rdata_ready, flush_pulse;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   logic [2:0]  ib_req_lines;
   logic [31:0] s_axi_rdata, up_data, ib_req_addr, ib_rdata, rd;
   int          fails = 0, compares = 0, cyc = 0;

   ppc_prefetch_ctrl dut_u (.*);
   ppc_ib_model ib_u (.*);

   always #25 core_clk = ~core_clk;
   // whole run needs well under two thousand cycles
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         report_and_stop();
      end
   end

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic report_and_stop();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, tb;
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      forever begin
         @(negedge core_clk);
         ta = s_axi_awready;
         tw = s_axi_wready;
         tb = s_axi_bvalid;
         rsp = s_axi_bresp;
         @(posedge core_clk);
         if (ta) s_axi_awvalid <= 1'h0;
         if (tw) s_axi_wvalid <= 1'h0;
         if (tb) begin
            s_axi_bready <= 1'h0;
            break;
         end
      end
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      logic ta, tr;
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      forever begin
         @(negedge core_clk);
         ta = s_axi_arready;
         tr = s_axi_rvalid;
         rd = s_axi_rdata;
         rsp = s_axi_rresp;
         @(posedge core_clk);
         if (ta) s_axi_arvalid <= 1'h0;
         if (tr) begin
            s_axi_rready <= 1'h0;
            break;
         end
      end
      chk("reg", e, rd);
      chk("rresp", {30'h0, er}, {30'h0, rsp});
   endtask

   // miss: checks fetch size; hit: no fetch may be issued
   task automatic up_rd(input logic [1:0] c, input logic [31:0] a, input int n,
                        input logic miss, input logic [2:0] ln);
      int   k;
      logic f;
      k = 0;
      f = 1'h0;
      @(posedge core_clk);
      up_req_valid <= 1'h1;
      up_req_cmd <= c;
      up_req_addr <= a;
      do @(negedge core_clk); while (!up_req_ready);
      @(posedge core_clk);
      up_req_valid <= 1'h0;
      do begin
         @(negedge core_clk);
         if (ib_req_valid && !f) chk("lines", {29'h0, ln}, {29'h0, ib_req_lines});
         f = f | ib_req_valid;
      end while (!up_xfer_open);
      chk("fetched", {31'h0, miss}, {31'h0, f});
      @(posedge core_clk);
      up_data_ready <= 1'h1;
      while (k < n) begin
         @(negedge core_clk);
         if (up_data_valid && up_xfer_open) begin
            chk("data", ~(a + 32'(4 * k)), up_data);
            k++;
         end
      end
      @(posedge core_clk);
      up_data_ready <= 1'h0;
      up_done <= 1'h1;
      @(posedge core_clk);
      up_done <= 1'h0;
   endtask

   task automatic ds_ev(input logic c, input logic w, input logic late, input logic e);
      @(posedge core_clk);
      ds_arrive <= 1'h1;
      ds_is_cfg <= c;
      ds_is_write <= w;
      @(posedge core_clk);
      ds_arrive <= 1'h0;
      @(negedge core_clk);
      chk("flush", {31'h0, e & ~late}, {31'h0, flush_pulse});
      if (late) begin
         @(posedge core_clk);
         ds_data_phase <= 1'h1;
         @(posedge core_clk);
         ds_data_phase <= 1'h0;
         @(negedge core_clk);
         chk("flush_late", {31'h0, e}, {31'h0, flush_pulse});
      end
   endtask

   task automatic t_regs();
      rdc(8'h5C, 32'h0000_0085, 2'h0);
      rdc(8'h60, 32'h0017_0ECA, 2'h0);
      rdc(8'h64, 32'h0000_00BA, 2'h0);
      rdc(8'h70, 32'h0, 2'h2);
      axw(8'h68, 32'hFFFF_FFFF);
      chk("ro_resp", 32'h0, {30'h0, rsp});
      axw(8'h60, 32'hFFFF_FFFF);
      rdc(8'h60, 32'h0017_7FFF, 2'h0);
      chk("mask", 32'h3, {30'h0, ib_mask_np_req, ib_mask_pf_req});
   endtask

   // adjustment off: every fetch uses the programmed size
   task automatic t_sizes();
      axw(8'h60, 32'h0017_0642);
      for (int i = 0; i < 6; i++) begin
         up_rd(2'(i % 3), 32'h1000 * (i + 1), 2, 1'h1, 3'(2 + 2 * (i % 3)));
      end
   endtask

   task automatic t_hit_flush();
      axw(8'h64, 32'h0000_00B2);
      ib_slow <= 1'h1;
      up_rd(2'h1, 32'h2000, 4, 1'h1, 3'h4);
      up_rd(2'h1, 32'h2010, 4, 1'h0, 3'h4);
      ds_ev(1'h0, 1'h1, 1'h1, 1'h1);
      up_rd(2'h1, 32'h2008, 2, 1'h1, 3'h4);
      ib_slow <= 1'h0;
   endtask

   // auto size: excess shrinks, a drained buffer grows, limits clamp
   task automatic t_adj();
      axw(8'h60, 32'h0003_200B);
      up_rd(2'h0, 32'h5000, 1, 1'h1, 3'h3);
      up_rd(2'h0, 32'h6000, 1, 1'h1, 3'h2);
      up_rd(2'h0, 32'h7000, 16, 1'h1, 3'h2);
      up_rd(2'h0, 32'h8000, 24, 1'h1, 3'h3);
      up_rd(2'h0, 32'h9000, 1, 1'h1, 3'h3);
      axw(8'h60, 32'h0013_200A);
      up_rd(2'h0, 32'hA000, 16, 1'h1, 3'h2);
      up_rd(2'h0, 32'hB000, 1, 1'h1, 3'h2);
   endtask

   task automatic t_kinds();
      for (int i = 0; i < 3; i++) begin
         axw(8'h64, 32'hF0 | (32'h1 << i));
         ds_ev(i == 0, i == 1, 1'h0, 1'h1);
         axw(8'h64, 32'hF7 ^ (32'h1 << i));
         ds_ev(i == 0, i == 1, 1'h0, 1'h0);
      end
   endtask

   task automatic t_pf_off();
      axw(8'h64, 32'h0);
      chk("mask", 32'h0, {30'h0, ib_mask_np_req, ib_mask_pf_req});
      up_rd(2'h2, 32'h3000, 1, 1'h1, 3'h0);
   endtask

   task automatic t_tmo();
      int k;
      k = 0;
      axw(8'h5C, 32'h2);
      axw(8'h64, 32'hB8);
      up_rd(2'h0, 32'h4000, 1, 1'h1, 3'h2);
      while (!flush_pulse && k < 40) begin
         @(negedge core_clk);
         k++;
      end
      chk("tmo_flush", 32'h1, {31'h0, flush_pulse});
   endtask

   initial begin
      repeat (5) @(posedge core_clk);
      rst_n <= 1'h1;
      t_regs();
      t_sizes();
      t_hit_flush();
      t_adj();
      t_kinds();
      t_pf_off();
      t_tmo();
      report_and_stop();
   end
endmodule

bind ppc_prefetch_ctrl ppc_prefetch_ctrl_asserts chk_u (.*);
`default_nettype wire
